// ===== rtl/act_pkg.sv
// constants, field layout and types for the adc computation and threshold block
package act_pkg;
    // register indices; byte address on apb is four times the index
    localparam logic [13:0] IDX_ERR_THR_CTRL = 14'h1d29;
    localparam logic [13:0] IDX_COMP_STATUS  = 14'h1d2a;
    localparam logic [13:0] IDX_REF_SELECT   = 14'h1d2b;
    localparam logic [13:0] IDX_CLK_DIVIDER  = 14'h1d2d;
    localparam logic [13:0] IDX_MODE_CTRL    = 14'h1d30;
    localparam logic [13:0] IDX_RUN_CTRL     = 14'h1d31;
    localparam logic [13:0] IDX_REPEAT       = 14'h1d32;
    localparam logic [13:0] IDX_UPPER        = 14'h1d33;
    localparam logic [13:0] IDX_LOWER        = 14'h1d34;
    localparam logic [13:0] IDX_SETPOINT     = 14'h1d35;
    localparam logic [13:0] IDX_ERROR        = 14'h1d36;
    localparam logic [13:0] IDX_FILTER       = 14'h1d37;
    localparam logic [13:0] IDX_ACCUM        = 14'h1d38;
    localparam logic [13:0] IDX_COUNT        = 14'h1d39;

    // field positions
    localparam int F_CALC   = 4;
    localparam int F_SOI    = 3;
    localparam int F_TMD    = 0;
    localparam int F_AOV    = 7;
    localparam int F_ABOVE_UPPER_FLAG   = 6;
    localparam int F_BELOW_LOWER_FLAG   = 5;
    localparam int F_COMPUTATION_UPDATED   = 4;
    localparam int F_STAGE  = 0;
    localparam int F_NEG_REFERENCE_SELECT   = 4;
    localparam int F_PREF   = 0;
    localparam int F_MODE   = 0;
    localparam int F_ACCUM_CLEAR_CMD   = 3;
    localparam int F_RSHIFT = 4;
    localparam int F_PREV_SOURCE_SELECT   = 7;
    localparam int F_RUN    = 0;
    localparam int F_CONTINUOUS_ENABLE   = 1;
    localparam int F_DOUBLE_SAMPLE_ENABLE   = 2;
    localparam int F_CSRC   = 3;

    // operating modes
    localparam logic [2:0] MD_BASIC = 3'h0;
    localparam logic [2:0] MD_ACCUM = 3'h1;
    localparam logic [2:0] MD_AVG   = 3'h2;
    localparam logic [2:0] MD_BURST = 3'h3;
    localparam logic [2:0] MD_LPF   = 3'h4;

    // error calculation codes
    localparam logic [2:0] CALC_RES_PREV  = 3'h0;
    localparam logic [2:0] CALC_RES_STPT  = 3'h1;
    localparam logic [2:0] CALC_RES_FILT  = 3'h2;
    localparam logic [2:0] CALC_PREV_FILT = 3'h4;
    localparam logic [2:0] CALC_FILT_STPT = 3'h5;

    // threshold interrupt codes
    localparam logic [2:0] TMD_NEVER   = 3'h0;
    localparam logic [2:0] TMD_BELOW   = 3'h1;
    localparam logic [2:0] TMD_ATLEAST = 3'h2;
    localparam logic [2:0] TMD_INSIDE  = 3'h3;
    localparam logic [2:0] TMD_OUTSIDE = 3'h4;
    localparam logic [2:0] TMD_ATMOST  = 3'h5;
    localparam logic [2:0] TMD_ABOVE   = 3'h6;
    localparam logic [2:0] TMD_ALWAYS  = 3'h7;

    // cycle stage codes; core stage 0 idle, 1 precharge, 2 acquisition, 3 conversion
    localparam logic [2:0] STG_IDLE      = 3'h0;
    localparam logic [2:0] STG_SUSPENDED = 3'h4;
    localparam logic [1:0] CORE_IDLE     = 2'h0;

    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_BUSY,
        SEQ_PAUSED
    } act_seq_e;
endpackage

// ===== rtl/act_clk_div.sv
// conversion clock divider from the system clock
`timescale 1ns/1ps
module act_clk_div
    import act_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       enable,
    input  wire logic [5:0] div_value,
    output logic            conv_clk
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       level;
    } act_div_s;

    act_div_s s_q;
    act_div_s s_d;

    // held low when the rc source is chosen
    always_comb begin
        s_d = s_q;
        if (!enable) begin
            s_d.cnt   = 6'h00;
            s_d.level = 1'b0;
        end else if (s_q.cnt >= div_value) begin
            s_d.cnt   = 6'h00;
            s_d.level = ~s_q.level;
        end else begin
            s_d.cnt = s_q.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign conv_clk = s_q.level;
endmodule

// ===== rtl/act_core.sv
// computation, threshold and status logic of the adc with apb registers
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module act_core
    import act_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  core_stage,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             conv_trigger,
    output logic             conv_clk,
    output logic             conv_clk_sel_rc,
    output logic             neg_ref_sel,
    output logic      [1:0]  pos_ref_sel,
    output logic             threshold_irq_pulse,
    output logic             run_active
);
    typedef struct packed {
        logic [2:0]  op_mode;
        logic [2:0]  rshift;
        logic        accum_clear_cmd;
        logic        prev_source_select;
        logic        run;
        logic        continuous_enable;
        logic        double_sample_enable;
        logic        csrc;
        logic [7:0]  rpt;
        logic [2:0]  calc;
        logic        stop_on_threshold;
        logic [2:0]  tmd;
        logic        accum_overflow_flag;
        logic        above_upper_flag;
        logic        below_lower_flag;
        logic        computation_updated;
        logic        neg_reference_select;
        logic [1:0]  pref;
        logic [5:0]  div;
        logic [15:0] uth;
        logic [15:0] lth;
        logic [15:0] stpt;
        logic [15:0] err;
        logic [15:0] filt;
        logic [15:0] prev;
        logic [11:0] res;
        logic [17:0] acc;
        logic [7:0]  cnt;
        act_seq_e    seq;
        logic        second;
        logic        trig;
        logic        irq;
        logic [31:0] rdata;
    } act_state_s;

    act_state_s s_q;
    act_state_s s_d;

    // word index of an aligned apb address
    function automatic logic [13:0] reg_index(input logic [15:0] addr);
        return addr[15:2];
    endfunction

    // true for any aligned address of an implemented register index
    function automatic logic reg_mapped(input logic [15:0] addr);
        logic [13:0] i;
        i = reg_index(addr);
        return (addr[1:0] == 2'h0) &&
               (i == IDX_ERR_THR_CTRL || i == IDX_COMP_STATUS || i == IDX_REF_SELECT ||
                i == IDX_CLK_DIVIDER  || (i >= IDX_MODE_CTRL && i <= IDX_COUNT));
    endfunction

    logic [2:0] stage;
    logic       wr;
    logic       rd_setup;

    assign wr       = psel && penable && pwrite && reg_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    // stage from the core and the pair position
    // stage is only as good as core_stage seen on this clock
    // suspended while waiting for the second trigger
    assign stage = (core_stage != CORE_IDLE) ? {s_q.second, core_stage} :
                   (s_q.seq == SEQ_PAUSED)   ? STG_SUSPENDED : STG_IDLE;

    // working values of one completed conversion
    logic [18:0] acc_sum;
    logic [17:0] acc_new;
    logic [17:0] shifted;
    logic [15:0] filt_new;
    logic        acc_ovf;
    logic        filt_ovf;
    logic        avg_ready;
    logic signed [17:0] base;
    logic signed [17:0] err_wide;
    logic        err_valid;
    logic        err_ovf;
    logic        above;
    logic        below;
    logic        hit;
    logic        first_of_pair;

    always_comb begin
        // computation only after the second of a pair
        first_of_pair = s_q.double_sample_enable && !s_q.second;
        avg_ready = 1'b1;
        acc_sum   = {1'b0, s_q.acc};
        unique case (s_q.op_mode)
            MD_ACCUM: acc_sum = {1'b0, s_q.acc} + {7'h00, conv_data};
            // a finished set restarts with this sample
            MD_AVG, MD_BURST: acc_sum = (s_q.cnt >= s_q.rpt) ? {7'h00, conv_data}
                                        : {1'b0, s_q.acc} + {7'h00, conv_data};
            MD_LPF: acc_sum = {1'b0, s_q.acc} - {1'b0, s_q.acc >> s_q.rshift}
                              + {7'h00, conv_data};
            default: acc_sum = {1'b0, s_q.acc};
        endcase
        acc_new  = acc_sum[17:0];
        acc_ovf  = acc_sum[18];
        shifted  = acc_new >> s_q.rshift;
        filt_new = shifted[15:0];
        filt_ovf = (shifted[17:16] != 2'h0);
        if (s_q.op_mode == MD_BASIC || s_q.op_mode > MD_LPF) begin
            filt_new = s_q.filt;
            filt_ovf = 1'b0;
        end
        if (s_q.op_mode == MD_AVG || s_q.op_mode == MD_BURST) begin
            avg_ready = (s_q.cnt >= s_q.rpt) ? (s_q.rpt <= 8'h01) : (s_q.cnt + 8'h01 >= s_q.rpt);
        end
        // double sample takes current minus previous first
        base = $signed({6'h00, conv_data})
               - (s_q.double_sample_enable ? $signed({2'h0, s_q.prev}) : 18'sh0_0000);
        err_valid = 1'b1;
        unique case (s_q.calc)
            CALC_RES_PREV:  err_wide = $signed({6'h00, conv_data}) - $signed({2'h0, s_q.prev});
            CALC_RES_STPT:  err_wide = base - $signed({{2{s_q.stpt[15]}}, s_q.stpt});
            CALC_RES_FILT:  err_wide = base - $signed({2'h0, filt_new});
            CALC_PREV_FILT: err_wide = $signed({2'h0, s_q.prev}) - $signed({2'h0, filt_new});
            CALC_FILT_STPT: err_wide = $signed({2'h0, filt_new})
                                       - $signed({{2{s_q.stpt[15]}}, s_q.stpt});
            default: begin
                err_wide  = $signed({{2{s_q.err[15]}}, s_q.err});
                err_valid = 1'b0;
            end
        endcase
        err_ovf = err_wide[17:15] != {3{err_wide[15]}};
        above = $signed(err_wide[15:0]) > $signed(s_q.uth);
        below = $signed(err_wide[15:0]) < $signed(s_q.lth);
        unique case (s_q.tmd)
            TMD_NEVER:   hit = 1'b0;
            TMD_BELOW:   hit = below;
            TMD_ATLEAST: hit = !below;
            TMD_INSIDE:  hit = !below && !above && ($signed(err_wide[15:0]) != $signed(s_q.lth))
                               && ($signed(err_wide[15:0]) != $signed(s_q.uth));
            TMD_OUTSIDE: hit = below || above;
            TMD_ATMOST:  hit = !above;
            TMD_ABOVE:   hit = above;
            TMD_ALWAYS:  hit = 1'b1;
        endcase
    end

    // next state: register writes, conversion bookkeeping, hardware flags
    always_comb begin
        s_d      = s_q;
        s_d.trig = 1'b0;
        s_d.irq  = 1'b0;
        // clear finishes in one cycle, then the bit drops
        if (s_q.accum_clear_cmd) begin
            s_d.acc  = 18'h0_0000;
            s_d.cnt  = 8'h00;
            s_d.accum_overflow_flag  = 1'b0;
            s_d.accum_clear_cmd = 1'b0;
        end
        // conversion starts: previous value captured
        if (s_q.trig) begin
            s_d.prev = s_q.prev_source_select ? s_q.filt : {4'h0, s_q.res};
            s_d.seq  = SEQ_BUSY;
        end
        // software clears come first, so a hardware set below wins
        if (wr && reg_index(paddr) == IDX_COMP_STATUS) begin
            s_d.accum_overflow_flag  = s_d.accum_overflow_flag && pwdata[F_AOV];
            s_d.computation_updated = s_d.computation_updated && (pwdata[F_COMPUTATION_UPDATED] || stage == STG_SUSPENDED);
        end
        if (conv_done && s_q.run) begin
            s_d.res = conv_data;
            if (first_of_pair) begin
                s_d.second = 1'b1;
                if (s_q.continuous_enable) begin
                    s_d.trig = 1'b1;
                end else begin
                    // pause until software triggers the second sample
                    s_d.run = 1'b0;
                    s_d.seq = SEQ_PAUSED;
                end
            end else begin
                s_d.second = 1'b0;
                s_d.seq    = SEQ_IDLE;
                if (s_q.op_mode != MD_BASIC && s_q.op_mode <= MD_LPF) begin
                    s_d.acc  = acc_new;
                    s_d.cnt  = (s_q.cnt >= s_q.rpt && s_q.op_mode != MD_ACCUM &&
                                s_q.op_mode != MD_LPF) ? 8'h01 : s_q.cnt + 8'h01;
                    s_d.computation_updated = 1'b1;
                    s_d.accum_overflow_flag  = s_d.accum_overflow_flag || acc_ovf || filt_ovf;
                end
                s_d.filt = avg_ready ? filt_new : s_q.filt;
                // one error update per completed pair
                if (avg_ready && err_valid) begin
                    s_d.err  = err_wide[15:0];
                    s_d.above_upper_flag = above;
                    s_d.below_lower_flag = below;
                    s_d.computation_updated = 1'b1;
                    s_d.irq  = hit;
                    s_d.accum_overflow_flag  = s_d.accum_overflow_flag || err_ovf;
                end
                // burst keeps converting until its set is full
                if (s_q.op_mode == MD_BURST && !avg_ready) begin
                    s_d.trig = 1'b1;
                end else if (s_q.continuous_enable) begin
                    // stop on threshold hit, else retrigger
                    if (s_q.stop_on_threshold && avg_ready && err_valid && hit) begin
                        s_d.run = 1'b0;
                    end else begin
                        s_d.trig = 1'b1;
                    end
                end else begin
                    s_d.run = 1'b0;
                end
            end
        end
        // software writes; status clears were taken before the hardware sets
        if (wr) begin
            unique case (reg_index(paddr))
                IDX_ERR_THR_CTRL: begin
                    s_d.calc = pwdata[F_CALC +: 3];
                    s_d.stop_on_threshold  = pwdata[F_SOI];
                    s_d.tmd  = pwdata[F_TMD +: 3];
                end
                IDX_REF_SELECT: begin
                    s_d.neg_reference_select = pwdata[F_NEG_REFERENCE_SELECT];
                    s_d.pref = pwdata[F_PREF +: 2];
                end
                IDX_CLK_DIVIDER: s_d.div = pwdata[5:0];
                IDX_MODE_CTRL: begin
                    s_d.op_mode = pwdata[F_MODE +: 3];
                    s_d.rshift  = pwdata[F_RSHIFT +: 3];
                    s_d.prev_source_select    = pwdata[F_PREV_SOURCE_SELECT];
                    s_d.accum_clear_cmd    = s_q.accum_clear_cmd | pwdata[F_ACCUM_CLEAR_CMD];
                end
                IDX_RUN_CTRL: begin
                    s_d.continuous_enable = pwdata[F_CONTINUOUS_ENABLE];
                    s_d.double_sample_enable = pwdata[F_DOUBLE_SAMPLE_ENABLE];
                    s_d.csrc = pwdata[F_CSRC];
                    if (!pwdata[F_RUN]) begin
                        s_d.run  = 1'b0;
                        s_d.trig = 1'b0;
                    end else if (!s_q.run) begin
                        s_d.run  = 1'b1;
                        s_d.trig = 1'b1;
                    end
                end
                IDX_REPEAT:   s_d.rpt  = pwdata[7:0];
                IDX_UPPER:    s_d.uth  = pwdata[15:0];
                IDX_LOWER:    s_d.lth  = pwdata[15:0];
                IDX_SETPOINT: s_d.stpt = pwdata[15:0];
                default: ;
            endcase
        end
        // read data captured in the setup phase
        if (rd_setup) begin
            s_d.rdata = RD_ZERO;
            unique case (reg_index(paddr))
                IDX_ERR_THR_CTRL: s_d.rdata[7:0] = {1'b0, s_q.calc, s_q.stop_on_threshold, s_q.tmd};
                IDX_COMP_STATUS:  s_d.rdata[7:0] = {s_q.accum_overflow_flag, s_q.above_upper_flag, s_q.below_lower_flag, s_q.computation_updated,
                                                    1'b0, stage};
                IDX_REF_SELECT:   s_d.rdata[7:0] = {3'h0, s_q.neg_reference_select, 2'h0, s_q.pref};
                IDX_CLK_DIVIDER:  s_d.rdata[7:0] = {2'h0, s_q.div};
                IDX_MODE_CTRL:    s_d.rdata[7:0] = {s_q.prev_source_select, s_q.rshift, s_q.accum_clear_cmd, s_q.op_mode};
                IDX_RUN_CTRL:     s_d.rdata[7:0] = {4'h0, s_q.csrc, s_q.double_sample_enable, s_q.continuous_enable, s_q.run};
                IDX_REPEAT:       s_d.rdata[7:0] = s_q.rpt;
                IDX_UPPER:        s_d.rdata[15:0] = s_q.uth;
                IDX_LOWER:        s_d.rdata[15:0] = s_q.lth;
                IDX_SETPOINT:     s_d.rdata[15:0] = s_q.stpt;
                IDX_ERROR:        s_d.rdata[15:0] = s_q.err;
                IDX_FILTER:       s_d.rdata[15:0] = s_q.filt;
                IDX_ACCUM:        s_d.rdata[17:0] = s_q.acc;
                IDX_COUNT:        s_d.rdata[7:0] = s_q.cnt;
                default:          s_d.rdata = RD_ZERO;
            endcase
            if (!reg_mapped(paddr)) begin
                s_d.rdata = RD_ZERO;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // divider runs only from the system clock source
    act_clk_div u_div (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .enable    (!s_q.csrc),
        .div_value (s_q.div),
        .conv_clk  (conv_clk)
    );

    // zero wait state slave; unmapped access answers with an error
    assign pready              = 1'b1;
    assign pslverr             = psel && penable && !reg_mapped(paddr);
    assign prdata              = s_q.rdata;
    assign conv_trigger        = s_q.trig;
    assign conv_clk_sel_rc     = s_q.csrc;
    assign neg_ref_sel         = s_q.neg_reference_select;
    assign pos_ref_sel         = s_q.pref;
    assign threshold_irq_pulse = s_q.irq;
    assign run_active          = s_q.run;
endmodule

// ===== test/act_core_checker.sv
// port assertions and cover points for the computation block
`timescale 1ns/1ps
module act_core_checker
    import act_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        conv_done,
    input wire logic        conv_trigger,
    input wire logic        neg_ref_sel,
    input wire logic [1:0]  pos_ref_sel,
    input wire logic        threshold_irq_pulse,
    input wire logic        run_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a completed write, the edge where a register loads
    wire wr_acc = psel && penable && pwrite;
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_phase: assert property (pslverr |-> psel && penable) else $error("pslverr early");
    a_trig_single: assert property (conv_trigger |=> !conv_trigger) else $error("long trig");
    a_irq_single: assert property (threshold_irq_pulse |=> !threshold_irq_pulse)
        else $error("long threshold event");
    a_irq_cause: assert property (threshold_irq_pulse |-> $past(conv_done))
        else $error("threshold event without result");
    a_trig_cause: assert property (conv_trigger |-> $past(conv_done) || $past(wr_acc))
        else $error("trigger without cause");
    a_run_start: assert property (wr_acc && paddr == {IDX_RUN_CTRL, 2'b00} && pwdata[F_RUN]
        && !run_active |=> conv_trigger && run_active) else $error("run write did not start");
    a_ref_load: assert property (wr_acc && paddr == {IDX_REF_SELECT, 2'b00} |=>
        neg_ref_sel == $past(pwdata[F_NEG_REFERENCE_SELECT]) && pos_ref_sel == $past(pwdata[1:0]))
        else $error("reference fields not loaded");
    c_irq: cover property (threshold_irq_pulse);
    c_refused: cover property (pslverr);
    c_run_stop: cover property ($fell(run_active));
endmodule

bind act_core act_core_checker act_core_checker_i (.clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .conv_done, .conv_trigger, .neg_ref_sel, .pos_ref_sel,
    .threshold_irq_pulse, .run_active);

// ===== test/test_act_core.sv
// self-checking bench for the adc computation and threshold block
`timescale 1ns/1ps
module test_act_core
    import act_pkg::*;
;
    localparam logic [32:0] ALL_BITS = 33'h1_ffff_ffff;
    logic        clk, sys_rst, psel, penable, pwrite, conv_done, pready, pslverr;
    logic        conv_trigger, conv_clk, conv_clk_sel_rc, neg_ref_sel, threshold_irq_pulse;
    logic        run_active;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [11:0] conv_data;
    logic [1:0]  core_stage, pos_ref_sel;
    logic [32:0] exp_q[$], msk_q[$], m;
    int          fails, checked, trigs, used, irqs, e, d, k;
    longint      last_rise, per;
    act_core act_core_i (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .core_stage, .conv_done, .conv_data, .conv_trigger, .conv_clk,
        .conv_clk_sel_rc, .neg_ref_sel, .pos_ref_sel, .threshold_irq_pulse, .run_active);
    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic bail();
        fails++;
        finish_test();
    endtask
    task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer; the spare edge after it keeps back-to-back calls apart
    task automatic apb(logic [13:0] idx, logic wr, logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bail();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [13:0] idx, logic [32:0] ev, logic [32:0] mk);
        exp_q.push_back(ev);
        msk_q.push_back(mk);
        apb(idx, 1'b0, 32'h0000_0000);
    endtask
    // waits for a trigger, then plays one conversion of the core
    task automatic conv(int dv);
        int n;
        n = 0;
        while (trigs == used && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (trigs == used) bail();
        used++;
        core_stage <= 2'h3;
        @(posedge clk);
        conv_done <= 1'b1;
        conv_data <= dv[11:0];
        @(posedge clk);
        conv_done <= 1'b0;
        core_stage <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic hit(logic [2:0] t, int ev);
        logic [7:0] v;
        v = {1'b1, ev > 300, ev <= 300, ev < -300 || ev > 300, ev > -300 && ev < 300,
             ev >= -300, ev < -300, 1'b0};
        return v[t];
    endfunction
    // read data with its error flag against the oldest note; pulses counted
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            m = msk_q.pop_front();
            check("read", {pslverr, prdata} & m, exp_q.pop_front());
        end
        if (conv_trigger === 1'b1) trigs++;
        if (threshold_irq_pulse === 1'b1) irqs++;
    end
    // period of the divided clock, in ns
    always @(posedge conv_clk) begin
        per = $time - last_rise;
        last_rise = $time;
    end
    initial begin
        {psel, penable, pwrite, conv_done, sys_rst} = 5'h01;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        conv_data = 12'h000;
        core_stage = 2'h0;
        d = $urandom(43);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(IDX_COMP_STATUS, 33'h0, ALL_BITS);
        rd(14'h1d2c, 33'h1_0000_0000, ALL_BITS);
        apb(IDX_REF_SELECT, 1'b1, 32'h0000_0013);
        rd(IDX_REF_SELECT, 33'h13, ALL_BITS);
        check("ref", {neg_ref_sel, pos_ref_sel}, 33'h7);
        apb(IDX_CLK_DIVIDER, 1'b1, 32'h0000_0005);
        repeat (30) @(posedge clk);
        check("divider", per[32:0], 33'(2 * 6 * 40));
        apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0008);
        repeat (20) @(posedge clk);
        check("rc clock", {conv_clk_sel_rc, conv_clk}, 33'h2);
        apb(IDX_SETPOINT, 1'b1, 32'h0000_0800);
        apb(IDX_UPPER, 1'b1, 32'h0000_012c);
        apb(IDX_LOWER, 1'b1, 32'h0000_fed4);
        // each threshold test on a random result around the setpoint
        for (int t = 0; t < 8; t++) begin
            apb(IDX_ERR_THR_CTRL, 1'b1, {25'h0, CALC_RES_STPT, 1'b0, t[2:0]});
            d = 1648 + $urandom % 800;
            k = irqs;
            apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0001);
            conv(d);
            e = d - 2048;
            check("irq", 33'(irqs - k), 33'(hit(t[2:0], e)));
            rd(IDX_ERROR, 33'(e[15:0]), 33'hffff);
            rd(IDX_COMP_STATUS, 33'({e > 300, e < -300, 5'h0}), 33'h60);
        end
        apb(IDX_ERR_THR_CTRL, 1'b1, {25'h0, CALC_RES_PREV, 4'h0});
        apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0001);
        conv(d + 7);
        rd(IDX_ERROR, 33'h7, 33'hffff);
        // continuous run must retrigger, then stop once above the upper threshold
        apb(IDX_ERR_THR_CTRL, 1'b1, {25'h0, CALC_RES_STPT, 1'b0, TMD_ABOVE});
        apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0003);
        conv(2448);
        check("kept", 33'(run_active), 33'h1);
        apb(IDX_ERR_THR_CTRL, 1'b1, {25'h0, CALC_RES_STPT, 1'b1, TMD_ABOVE});
        conv(2048);
        check("rearmed", 33'(run_active), 33'h1);
        conv(2448);
        check("stopped", 33'(run_active), 33'h0);
        // a double-sample pair: paused stage, one error after the second sample
        apb(IDX_ERR_THR_CTRL, 1'b1, {25'h0, CALC_RES_STPT, 4'h0});
        apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0005);
        conv(1000);
        apb(IDX_COMP_STATUS, 1'b1, 32'h0000_0000); // computation_updated clear refused while suspended; accum_overflow_flag still cleared
        rd(IDX_COMP_STATUS, 33'h14, 33'h17);
        rd(IDX_ERROR, 33'h190, 33'hffff);
        apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0005);
        conv(3000);
        rd(IDX_ERROR, 33'hffd0, 33'hffff);
        apb(IDX_COMP_STATUS, 1'b1, 32'h0000_0000); // cleared by software when idle
        rd(IDX_COMP_STATUS, 33'h0, 33'h17);
        apb(IDX_REPEAT, 1'b1, 32'h0000_0002); // two samples for a shift of one
        apb(IDX_MODE_CTRL, 1'b1, {25'h0, 3'h1, 1'b0, MD_ACCUM}); // shift one, never 0 or 7
        apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0001);
        conv(d);
        rd(IDX_ACCUM, 33'(d), 33'h3_ffff);
        apb(IDX_MODE_CTRL, 1'b1, {25'h0, 3'h1, 1'b1, MD_ACCUM});
        rd(IDX_MODE_CTRL, 33'h11, 33'hff);
        rd(IDX_ACCUM, 33'h0, ALL_BITS);
        rd(IDX_COUNT, 33'h0, ALL_BITS);
        // average, then burst, over a set of two opened by an accumulator clear
        for (int mode = 2; mode < 4; mode++) begin
            apb(IDX_MODE_CTRL, 1'b1, {25'h0, 3'h1, 1'b1, mode[2:0]});
            for (int j = 0; j < 2; j++) begin
                apb(IDX_RUN_CTRL, 1'b1, 32'h0000_0001);
                conv(1000 + 4 * mode + 2 * j);
            end
            rd(IDX_FILTER, 33'(1001 + 4 * mode), 33'hffff);
        end
        finish_test();
    end
endmodule
